/* File: src/vectored_interrupt_controller.sv */
// vectored interrupt controller core: request latch, global enable, 3-level priority
// Behaviour
// - write one to enable sets global enable
// - mask, ack, write zero, traps clear enable
// - three levels, level 3 most urgent
// - higher level wins; fixed order within level
// - watchdog and traps always top priority
// - acknowledge clears winning source pending bit
// - writing zero clears pending bit
// - request pulse sets pending bit
// - enabled: vector to core; else poll
// - watchdog and oscillator traps bypass registers
// - pending bit layout; reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller
  import vic_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic        timerOneRequest,
  input  wire logic        timerZeroRequest,
  input  wire logic        serialRxRequest,
  input  wire logic        serialTxRequest,
  input  wire logic        converterRequest,
  input  wire logic        watchdogRequest,
  input  wire logic        globalMaskInstruction,
  input  wire logic        trapInstruction,
  input  wire logic        illegalTrap,
  input  wire logic        primaryOscFailTrap,
  input  wire logic        watchdogOscFailTrap,
  output logic             coreIrq,
  output logic      [3:0]  coreVector,
  output logic             coreTrapPending,
  input  wire logic        coreAck,
  output logic             globalEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] pending_reg;
  logic [7:0] enable_reg;
  logic [7:0] prioHi_reg;
  logic [7:0] prioLo_reg;
  logic       globalEnable_reg;
  logic       watchdogPend_reg;
  logic [7:0] pending_next;
  logic [7:0] reqPulse;
  logic [7:0] ackClear;
  logic [7:0] swClear;
  logic [1:0] level [8];
  logic [7:0] eligible;
  logic [1:0] bestLevel;
  logic [2:0] winBit;
  logic       winValid;

  assign reqPulse = {1'b0, timerOneRequest, timerZeroRequest, serialRxRequest,
                     serialTxRequest, 2'b00, converterRequest};
  assign globalEnable = globalEnable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // per-source priority level from hi/lo bit pairs; disabled sources sit at zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_level
      assign level[gi] = enable_reg[gi] ? {prioHi_reg[gi], prioLo_reg[gi]} : LEVEL_OFF;
      assign eligible[gi] = pending_reg[gi] && (level[gi] != LEVEL_OFF);
    end
  endgenerate

  // find highest level, then highest bit within it: bit 6 first, bit 0 last
  always_comb
  begin
    bestLevel = LEVEL_OFF;
    winBit    = 3'h0;
    winValid  = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (eligible[i] && level[i] > bestLevel)
        bestLevel = level[i];
    end
    for (int i = 0; i < 8; i++)
    begin
      if (eligible[i] && level[i] == bestLevel)
      begin
        winBit   = 3'(i);
        winValid = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector selection: bypass sources beat every programmable one
  always_comb
  begin
    coreTrapPending = primaryOscFailTrap || watchdogOscFailTrap || illegalTrap;
    if (watchdogPend_reg)
      coreVector = VEC_WATCHDOG;
    else if (!winValid)
      coreVector = VEC_NONE;
    else
    begin
      case (winBit)
        3'(TIMER_ONE_BIT):  coreVector = VEC_TIMER_ONE;
        3'(TIMER_ZERO_BIT): coreVector = VEC_TIMER_ZERO;
        3'(SERIAL_RX_BIT):  coreVector = VEC_SERIAL_RX;
        3'(SERIAL_TX_BIT):  coreVector = VEC_SERIAL_TX;
        default:            coreVector = VEC_CONVERTER;
      endcase
    end
  end

  // only forwarded while globally enabled; otherwise software polls
  assign coreIrq = globalEnable_reg && (watchdogPend_reg || winValid);

  ////////////////////////////////////////////////////////////////////////////
  // pending clears by acknowledge and by software zero writes
  always_comb
  begin
    ackClear = 8'h00;
    if (coreAck && coreIrq && !watchdogPend_reg)
      ackClear[winBit] = 1'b1;
    swClear = 8'h00;
    if (regWrite && regAddr == IRQ_REQ0_OFFSET)
      swClear = ~regWrData;
    // set wins over any clear in the same cycle
    pending_next = ((pending_reg & ~ackClear & ~swClear) | reqPulse) & IRQ_REQ0_MASK;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pending_reg <= IRQ_REQ0_RESET;
    else
      pending_reg <= pending_next;
  end

  // watchdog bypasses the request register; held until acknowledged
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      watchdogPend_reg <= 1'b0;
    else if (watchdogRequest)
      watchdogPend_reg <= 1'b1;
    else if (coreAck && coreIrq)
      watchdogPend_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // global enable: a disable event beats a write of one in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      globalEnable_reg <= 1'b0;
    else if (globalMaskInstruction || (coreAck && coreIrq) || trapInstruction
             || illegalTrap || primaryOscFailTrap || watchdogOscFailTrap)
      globalEnable_reg <= 1'b0;
    else if (regWrite && regAddr == IRQ_CTRL_OFFSET)
      globalEnable_reg <= regWrData[GLOBAL_ENABLE_BIT];
  end

  // enable and priority registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      enable_reg <= IRQ_ENABLE_RESET;
      prioHi_reg <= IRQ_PRIO_RESET;
      prioLo_reg <= IRQ_PRIO_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == IRQ_ENABLE_OFFSET)
        enable_reg <= regWrData & IRQ_REQ0_MASK;
      if (regAddr == IRQ_PRIOHI_OFFSET)
        prioHi_reg <= regWrData & IRQ_REQ0_MASK;
      if (regAddr == IRQ_PRIOLO_OFFSET)
        prioLo_reg <= regWrData & IRQ_REQ0_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      regRdData <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        IRQ_REQ0_OFFSET:   regRdData <= pending_reg;
        IRQ_CTRL_OFFSET:   regRdData <= {globalEnable_reg, 7'h00};
        IRQ_ENABLE_OFFSET: regRdData <= enable_reg;
        IRQ_PRIOHI_OFFSET: regRdData <= prioHi_reg;
        IRQ_PRIOLO_OFFSET: regRdData <= prioLo_reg;
        default:           regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_setEnable;
    @(posedge ref_clk) disable iff (rst)
    (regWrite && regAddr == IRQ_CTRL_OFFSET && regWrData[GLOBAL_ENABLE_BIT]
     && !globalMaskInstruction && !coreAck && !trapInstruction && !illegalTrap
     && !primaryOscFailTrap && !watchdogOscFailTrap) |=> globalEnable;
  endproperty
  a_setEnable: assert property (p_setEnable) else $error("enable not set");

  property p_maskClears;
    @(posedge ref_clk) disable iff (rst)
    (globalMaskInstruction || trapInstruction || illegalTrap) |=> !globalEnable;
  endproperty
  a_maskClears: assert property (p_maskClears) else $error("enable not cleared");

  property p_reqSets;
    @(posedge ref_clk) disable iff (rst)
    timerOneRequest |=> pending_reg[TIMER_ONE_BIT];
  endproperty
  a_reqSets: assert property (p_reqSets) else $error("request lost");

  property p_swClear;
    @(posedge ref_clk) disable iff (rst)
    (regWrite && regAddr == IRQ_REQ0_OFFSET && !regWrData[SERIAL_RX_BIT]
     && !serialRxRequest) |=> !pending_reg[SERIAL_RX_BIT];
  endproperty
  a_swClear: assert property (p_swClear) else $error("zero write did not clear");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
    (pending_reg & ~IRQ_REQ0_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_noIrqDisabled;
    @(posedge ref_clk) disable iff (rst)
    !globalEnable |-> !coreIrq;
  endproperty
  a_noIrqDisabled: assert property (p_noIrqDisabled) else $error("irq while disabled");

  property p_ackClears;
    @(posedge ref_clk) disable iff (rst)
    (coreAck && coreIrq && !watchdogPend_reg && winBit == 3'(CONVERTER_BIT)
     && !converterRequest) |=> !pending_reg[CONVERTER_BIT] && !globalEnable;
  endproperty
  a_ackClears: assert property (p_ackClears) else $error("ack did not clear");

  property p_levelOrder;
    @(posedge ref_clk) disable iff (rst)
    (coreIrq && !watchdogPend_reg && eligible[CONVERTER_BIT]
     && level[CONVERTER_BIT] == LEVEL_THREE) |-> level[winBit] == LEVEL_THREE;
  endproperty
  a_levelOrder: assert property (p_levelOrder) else $error("lower level won");

  property p_watchdogFirst;
    @(posedge ref_clk) disable iff (rst)
    watchdogPend_reg |-> coreVector == VEC_WATCHDOG;
  endproperty
  a_watchdogFirst: assert property (p_watchdogFirst) else $error("watchdog not first");

  property p_failTrapsClear;
    @(posedge ref_clk) disable iff (rst)
    (primaryOscFailTrap || watchdogOscFailTrap || (coreAck && coreIrq)) |=> !globalEnable;
  endproperty
  a_failTrapsClear: assert property (p_failTrapsClear) else $error("trap left enable set");

  property p_zeroWriteDisables;
    @(posedge ref_clk) disable iff (rst)
    (regWrite && regAddr == IRQ_CTRL_OFFSET && !regWrData[GLOBAL_ENABLE_BIT])
    |=> !globalEnable;
  endproperty
  a_zeroWriteDisables: assert property (p_zeroWriteDisables) else $error("enable kept");

  // watchdog takes the vector whatever the per-source registers hold
  property p_watchdogBypass;
    @(posedge ref_clk) disable iff (rst)
    watchdogRequest |=> coreVector == VEC_WATCHDOG;
  endproperty
  a_watchdogBypass: assert property (p_watchdogBypass) else $error("watchdog not vectored");

  // a polled request must survive until software clears it, no ack can reach it
  property p_polledHolds;
    @(posedge ref_clk) disable iff (rst)
    (!globalEnable && pending_reg[TIMER_ZERO_BIT]
     && !(regWrite && regAddr == IRQ_REQ0_OFFSET)) |=> pending_reg[TIMER_ZERO_BIT];
  endproperty
  a_polledHolds: assert property (p_polledHolds) else $error("polled request lost");

  property p_trapPending;
    @(posedge ref_clk) disable iff (rst)
    (illegalTrap || primaryOscFailTrap || watchdogOscFailTrap) |-> coreTrapPending;
  endproperty
  a_trapPending: assert property (p_trapPending) else $error("trap not flagged");

  c_watchdog: cover property (@(posedge ref_clk) disable iff (rst) watchdogPend_reg && coreAck);

  c_vectored: cover property (@(posedge ref_clk) disable iff (rst) coreIrq && coreAck);
  c_polled: cover property (@(posedge ref_clk) disable iff (rst)
    !globalEnable && pending_reg != 8'h00);
  c_setClear: cover property (@(posedge ref_clk) disable iff (rst)
    serialTxRequest && regWrite && regAddr == IRQ_REQ0_OFFSET);
endmodule
`default_nettype wire

/* File: src/vic_pkg.sv */
// package: register map, source bit positions and priority encodings for the interrupt controller
package vic_pkg;
  // register offsets (12-bit register port address)
  localparam logic [11:0] IRQ_REQ0_OFFSET   = 12'h0fc0;
  localparam logic [11:0] IRQ_CTRL_OFFSET   = 12'h0fc1;
  localparam logic [11:0] IRQ_ENABLE_OFFSET = 12'h0fc2;
  localparam logic [11:0] IRQ_PRIOHI_OFFSET = 12'h0fc3;
  localparam logic [11:0] IRQ_PRIOLO_OFFSET = 12'h0fc4;
  // pending bit positions in the request register
  localparam int TIMER_ONE_BIT  = 6;
  localparam int TIMER_ZERO_BIT = 5;
  localparam int SERIAL_RX_BIT  = 4;
  localparam int SERIAL_TX_BIT  = 3;
  localparam int CONVERTER_BIT  = 0;
  // control register: global enable bit position
  localparam int GLOBAL_ENABLE_BIT = 7;
  // writable (non-reserved) bits of the request register
  localparam logic [7:0] IRQ_REQ0_MASK  = 8'h79;
  localparam logic [7:0] IRQ_REQ0_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_PRIO_RESET   = 8'h00;
  // priority levels, {hi,lo}
  localparam logic [1:0] LEVEL_OFF = 2'h0;
  localparam logic [1:0] LEVEL_ONE = 2'h1;
  localparam logic [1:0] LEVEL_TWO = 2'h2;
  localparam logic [1:0] LEVEL_THREE = 2'h3;
  // vector numbers presented to the core
  localparam logic [3:0] VEC_NONE       = 4'h0;
  localparam logic [3:0] VEC_WATCHDOG   = 4'h1;
  localparam logic [3:0] VEC_TIMER_ONE  = 4'h2;
  localparam logic [3:0] VEC_TIMER_ZERO = 4'h3;
  localparam logic [3:0] VEC_SERIAL_RX  = 4'h4;
  localparam logic [3:0] VEC_SERIAL_TX  = 4'h5;
  localparam logic [3:0] VEC_CONVERTER  = 4'h6;
endpackage

/* File: sim/core_ack_model.sv */
// processor core model: takes vectored requests after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module core_ack_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       coreIrq,
  input  wire logic [3:0] coreVector,
  input  wire logic [1:0] ackDelay,
  output logic            coreAck,
  output logic      [3:0] takenVector,
  output logic      [7:0] ackCount
);
  logic [1:0] waitCnt;
  ////////////////////////////////////////////////////////////////////////////////
  // ack is one cycle and only while the request stands; delay 0 is prompt
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      coreAck     <= 1'b0;
      takenVector <= 4'h0;
      ackCount    <= 8'h00;
      waitCnt     <= 2'h0;
    end
    else
    begin
      coreAck <= 1'b0;
      if (coreIrq && !coreAck && waitCnt == ackDelay)
      begin
        coreAck     <= 1'b1;
        takenVector <= coreVector;
        ackCount    <= ackCount + 8'h01;
        waitCnt     <= 2'h0;
      end
      else if (coreIrq && !coreAck)
        waitCnt <= waitCnt + 2'h1;
      else
        waitCnt <= 2'h0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/vectored_interrupt_controller_tb.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb;
  import vic_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdData;
  logic [7:0]  srcReq = 8'h00;   // pulses in request-register bit positions
  logic        wdReq = 1'b0;
  logic [4:0]  evt = 5'h00;      // mask, trap, illegal, osc fail, wdt osc fail
  logic        coreIrq, coreTrapPending, coreAck, globalEnable;
  logic [3:0]  coreVector, takenVector;
  logic [1:0]  ackDelay = 2'h0;
  logic [7:0]  ackCount, prev, rdv;
  logic [31:0] seed = 32'he38e;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          pend, wd, en, hi, lo, w, t;
  int          bitPos[5] = '{6, 5, 4, 3, 0};
  ////////////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #4 ref_clk = ~ref_clk;
  vectored_interrupt_controller DUT (.ref_clk, .rst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .timerOneRequest(srcReq[6]), .timerZeroRequest(srcReq[5]),
    .serialRxRequest(srcReq[4]), .serialTxRequest(srcReq[3]), .converterRequest(srcReq[0]),
    .watchdogRequest(wdReq), .globalMaskInstruction(evt[0]), .trapInstruction(evt[1]),
    .illegalTrap(evt[2]), .primaryOscFailTrap(evt[3]), .watchdogOscFailTrap(evt[4]),
    .coreIrq, .coreVector, .coreTrapPending, .coreAck, .globalEnable);
  core_ack_model coreModel (.ref_clk, .rst, .coreIrq, .coreVector, .ackDelay, .coreAck,
    .takenVector, .ackCount);
  ////////////////////////////////////////////////////////////////////////////////
  // reference model, stimulus and compare helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // watchdog first, then level 3 down, bit 6 first inside a level
  function automatic int winner();
    if (wd != 0) return 1;
    for (int lvl = 3; lvl > 0; lvl--)
      for (int k = 0; k < 5; k++)
        if (pend[bitPos[k]] && en[bitPos[k]] && hi[bitPos[k]] * 2 + lo[bitPos[k]] == lvl)
          return k + 2;
    return 0;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask
  // one-cycle pulses only; held levels would re-latch
  task automatic pulse(input logic [7:0] s, input logic v);
    @(posedge ref_clk);
    srcReq <= s;
    wdReq <= v;
    @(posedge ref_clk);
    srcReq <= 8'h00;
    wdReq <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkv(input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH vector expected %h seen %h", e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      rd(IRQ_REQ0_OFFSET + 12'(a), rdv);
      chk("reset", 8'h00, rdv);
    end
    pulse(8'hff, 1'b0);
    rd(IRQ_REQ0_OFFSET, rdv);
    chk("latched", 8'h79, rdv);
    chk("polled irq", 8'h00, {7'h0, coreIrq});
    wr(IRQ_REQ0_OFFSET, 8'h71);
    rd(IRQ_REQ0_OFFSET, rdv);
    chk("zero clears", 8'h71, rdv);
    wr(IRQ_REQ0_OFFSET, 8'h00);
    fork
      wr(IRQ_REQ0_OFFSET, 8'h00);
      pulse(8'h40, 1'b0);
    join
    rd(IRQ_REQ0_OFFSET, rdv);
    chk("set beats clear", 8'h40, rdv);
    wr(IRQ_REQ0_OFFSET, 8'h00);
    $display("test request register done");
    for (int i = 0; i < 5; i++)
    begin
      wr(IRQ_CTRL_OFFSET, 8'h80);
      rd(IRQ_CTRL_OFFSET, rdv);
      chk("enable", 8'h80, rdv);
      @(posedge ref_clk);
      evt <= 5'(1 << i);
      @(negedge ref_clk);
      chk("trap", {7'h0, i >= 2}, {7'h0, coreTrapPending});
      @(posedge ref_clk);
      evt <= 5'h00;
      rd(IRQ_CTRL_OFFSET, rdv);
      chk("disable event", 8'h00, rdv);
    end
    wr(IRQ_CTRL_OFFSET, 8'h80);
    wr(IRQ_CTRL_OFFSET, 8'h00);
    rd(IRQ_CTRL_OFFSET, rdv);
    chk("write zero", 8'h00, rdv);
    $display("test global enable done");
    pend = 0;
    wd = 0;
    for (int it = 0; it < 16; it++)
    begin
      seed = xs(seed);
      en = seed[7:0] & 8'h79;
      hi = seed[15:8] & 8'h79;
      lo = seed[23:16] & 8'h79;
      // raw random bytes: reserved bits must read back as zero
      wr(IRQ_ENABLE_OFFSET, seed[7:0]);
      wr(IRQ_PRIOHI_OFFSET, seed[15:8]);
      wr(IRQ_PRIOLO_OFFSET, seed[23:16]);
      rd(IRQ_ENABLE_OFFSET, rdv);
      chk("enable reg", 8'(en), rdv);
      rd(IRQ_PRIOHI_OFFSET, rdv);
      chk("prio hi reg", 8'(hi), rdv);
      rd(IRQ_PRIOLO_OFFSET, rdv);
      chk("prio lo reg", 8'(lo), rdv);
      seed = xs(seed);
      ackDelay <= seed[10:9];
      pulse(seed[7:0] & 8'h79, seed[8]);
      pend = pend | (seed[7:0] & 8'h79);
      wd = seed[8];
      rd(IRQ_REQ0_OFFSET, rdv);
      chk("pending", 8'(pend), rdv);
      chk("polled irq", 8'h00, {7'h0, coreIrq});
      for (int g = 0; g < 7; g++)
      begin
        w = winner();
        if (w == 0) break;
        prev = ackCount;
        wr(IRQ_CTRL_OFFSET, 8'h80);
        for (t = 0; t < 20 && ackCount === prev; t++) @(posedge ref_clk);
        if (t == 20)
        begin
          n_fail++;
          end_of_test();
        end
        chkv(4'(w), takenVector);
        if (w == 1) wd = 0;
        else pend[bitPos[w - 2]] = 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(IRQ_CTRL_OFFSET, rdv);
        chk("ack disables", 8'h00, rdv | {globalEnable, 7'h00});
      end
      rd(IRQ_REQ0_OFFSET, rdv);
      chk("ack clears", 8'(pend), rdv);
      chkv(VEC_NONE, coreVector);
    end
    $display("test priority done");
    end_of_test();
  end
endmodule
`default_nettype wire
